// ---- adc_control_byte_power_modes.sv ----
// control-byte decoder and power-mode sequencer of an eight-channel serial converter
// assumes the host drives sclk, cs_n and din, and presents din before each rising sclk
// Functional notes
// [RULE1] power-up without shutdown gives normal mode, strobe low
// [RULE2] no conversion during the 10 us reset
// [RULE3] first one with select low is start bit
// [RULE4] output shifts zeros before first conversion
// [RULE5] between conversions sit in last programmed power state
// [RULE6] two low bits pick the power mode
// [RULE7] shutdown pin low forces hardware shutdown
// [RULE8] software low power only after conversion ends
// [RULE9] shutdown wins and aborts conversion at once
// [RULE10] new byte in power-down converts at full power
// [RULE11] eight bits, msb first, msb is start
// [RULE12] bits 6 to 4 select the channel
// [RULE13] bit 3 selects unipolar or bipolar
// [RULE14] bit 2 selects single-ended or pseudo-differential
// [RULE15] one input bit on each rising serial clock
// [RULE16] strobe high one serial period after byte
// [RULE17] twelve result bits on falling edges, msb first
// [RULE18] select high releases strobe and data output
// [RULE19] fields update only after a complete byte
// [RULE20] after shutdown release, idle with nothing pending
module adc_control_byte_power_modes
  import adc_ctl_pkg::*;
#(
  parameter int POR_CYCLES_P = POR_CYCLES
)
(
  input  wire logic                   clk,
  input  wire logic                   rst,
  input  wire logic                   sclk,
  input  wire logic                   cs_n,
  input  wire logic                   din,
  input  wire logic                   hw_power_off_n,
  input  wire logic [RESULT_BITS-1:0] result_data,
  output logic                        dout,
  output logic                        dout_oe,
  output logic                        conversion_strobe,
  output logic                        strobe_oe,
  output logic                        channel_select_b2,
  output logic                        channel_select_b1,
  output logic                        channel_select_b0,
  output logic                        polarity_select,
  output logic                        input_config_select,
  output logic                        power_mode_hi,
  output logic                        power_mode_lo,
  output power_state_t                power_state,
  output logic                        conv_ready
);

  logic                   link_rst;
  logic                   oe_clr;
  link_state_t            state_reg;
  logic [2:0]             bit_cnt_reg;
  logic [6:0]             shift_reg;
  logic [3:0]             conv_cnt_reg;
  logic [RESULT_BITS-1:0] result_reg;
  logic                   start_tgl_reg;
  logic                   done_tgl_reg;
  logic                   ready_link;
  logic                   dout_reg;
  logic                   strobe_reg;
  logic                   oe_reg;
  logic [CTRL_WIDTH-1:0]  ctrl_word;
  logic                   byte_done;
  logic [2:0]             clk_side_sync;

  // shutdown resets the link side directly so a conversion stops mid-way
  assign link_rst  = rst | ~hw_power_off_n; // [RULE9]
  assign oe_clr    = link_rst | cs_n;
  assign ctrl_word = {shift_reg, din};
  assign byte_done = (state_reg == LINK_SHIFT) && !cs_n && (bit_cnt_reg == BIT_LAST);

  assign dout              = dout_reg;
  assign conversion_strobe = strobe_reg;
  assign dout_oe           = oe_reg;
  assign strobe_oe         = oe_reg;

  // ==========================================================================
  // crossings
  level_sync #(
    .WIDTH       (1),
    .RESET_VALUE (1'b0)
  ) ready_to_link (
    .clk      (sclk),
    .rst      (link_rst),
    .async_in (conv_ready),
    .sync_out (ready_link)
  );

  level_sync #(
    .WIDTH       (3),
    .RESET_VALUE (3'h4)
  ) link_to_clk (
    .clk      (clk),
    .rst      (rst),
    .async_in ({hw_power_off_n, start_tgl_reg, done_tgl_reg}),
    .sync_out (clk_side_sync)
  );

  power_sequencer #(
    .POR_CYCLES_P (POR_CYCLES_P)
  ) sequencer (
    .clk            (clk),
    .rst            (rst),
    .hw_power_off_n_n_sync    (clk_side_sync[2]),
    .start_tgl_sync (clk_side_sync[1]),
    .done_tgl_sync  (clk_side_sync[0]),
    .mode_hi        (power_mode_hi),
    .mode_lo        (power_mode_lo),
    .power_state    (power_state),
    .conv_ready     (conv_ready)
  );

  // ==========================================================================
  // link state machine, rising sclk
  always_ff @(posedge sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      state_reg    <= LINK_HUNT;
      bit_cnt_reg  <= '0;
      shift_reg    <= '0;
      conv_cnt_reg <= CONV_FIRST;
    end
    else
    begin
      unique case (state_reg)
        LINK_HUNT:
        begin
          if (!cs_n && din && ready_link) // [RULE2] [RULE3]
          begin
            shift_reg   <= 7'h01;
            bit_cnt_reg <= BIT_FIRST;
            state_reg   <= LINK_SHIFT;
          end
        end
        LINK_SHIFT:
        begin
          if (!cs_n)
          begin
            shift_reg   <= {shift_reg[5:0], din}; // [RULE11] [RULE15]
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            if (bit_cnt_reg == BIT_LAST)
            begin
              state_reg    <= LINK_CONVERT;
              conv_cnt_reg <= CONV_FIRST;
            end
          end
        end
        LINK_CONVERT:
        begin
          if (conv_cnt_reg == CONV_LAST)
            state_reg <= LINK_HUNT;
          else
            conv_cnt_reg <= conv_cnt_reg + 4'h1;
        end
      endcase
    end
  end

  // ==========================================================================
  // decoded control fields
  always_ff @(posedge sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      {channel_select_b2, channel_select_b1, channel_select_b0} <= CHAN_RESET;
      polarity_select                   <= POL_RESET;
      input_config_select               <= CFG_RESET;
      {power_mode_hi, power_mode_lo}    <= PD_RESET;
    end
    else if (byte_done) // [RULE19]
    begin
      {channel_select_b2, channel_select_b1, channel_select_b0}
                                     <= ctrl_word[CHAN_MSB:CHAN_LSB]; // [RULE12]
      polarity_select                <= ctrl_word[POL_BIT]; // [RULE13]
      input_config_select            <= ctrl_word[CFG_BIT]; // [RULE14]
      {power_mode_hi, power_mode_lo} <= ctrl_word[PD_HI_BIT:PD_LO_BIT]; // [RULE6]
    end
  end

  // ==========================================================================
  // result capture and shift
  always_ff @(posedge sclk or posedge link_rst)
  begin
    if (link_rst)
      result_reg <= '0;
    else if (byte_done)
      result_reg <= result_data;
    else if (state_reg == LINK_CONVERT && conv_cnt_reg != CONV_FIRST)
      result_reg <= {result_reg[RESULT_BITS-2:0], 1'b0}; // [RULE17]
  end

  // ==========================================================================
  // event toggles towards the system clock
  always_ff @(posedge sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      start_tgl_reg <= 1'b0;
      done_tgl_reg  <= 1'b0;
    end
    else
    begin
      if (byte_done)
        start_tgl_reg <= ~start_tgl_reg; // [RULE10]
      if (state_reg == LINK_CONVERT && conv_cnt_reg == CONV_LAST)
        done_tgl_reg <= ~done_tgl_reg; // [RULE8]
    end
  end

  // ==========================================================================
  // output stage, falling sclk
  always_ff @(negedge sclk or posedge link_rst)
  begin
    if (link_rst)
    begin
      strobe_reg <= 1'b0; // [RULE1]
      dout_reg   <= 1'b0;
    end
    else
    begin
      strobe_reg <= (state_reg == LINK_CONVERT) && (conv_cnt_reg == CONV_FIRST); // [RULE16]
      dout_reg   <= (state_reg == LINK_CONVERT) && (conv_cnt_reg != CONV_FIRST)
                    && result_reg[RESULT_BITS-1]; // [RULE4] [RULE17]
    end
  end

  // drivers off while select is high
  always_ff @(negedge sclk or posedge oe_clr)
  begin
    if (oe_clr)
      oe_reg <= 1'b0; // [RULE18]
    else
      oe_reg <= 1'b1;
  end

  // ==========================================================================
  // checks
  sequence byte_body_s;
    (state_reg == LINK_SHIFT) [*7] ##1 (state_reg == LINK_CONVERT);
  endsequence

  sequence result_body_s;
    (state_reg == LINK_CONVERT) [*8] ##1 (state_reg == LINK_CONVERT) [*5]
      ##1 (state_reg == LINK_HUNT);
  endsequence

  start_take_a: assert property (@(posedge sclk) disable iff (link_rst)
    (state_reg == LINK_HUNT && !cs_n && din && ready_link) |=> state_reg == LINK_SHIFT) // [RULE3]
    else $error("start bit not taken");

  no_early_a: assert property (@(posedge sclk) disable iff (link_rst)
    (state_reg == LINK_HUNT && !ready_link) |=> state_reg == LINK_HUNT) // [RULE2]
    else $error("start accepted during reset interval");

  byte_length_a: assert property (@(posedge sclk) disable iff (link_rst || cs_n)
    $rose(state_reg == LINK_SHIFT) |-> byte_body_s) // [RULE11]
    else $error("control byte not eight bits");

  // a change without a byte end can only be the return to reset values
  field_hold_a: assert property (@(posedge sclk) disable iff (link_rst)
    !$stable({polarity_select, input_config_select, power_mode_hi, power_mode_lo})
    |-> $past(byte_done)
        || ({polarity_select, input_config_select, power_mode_hi, power_mode_lo}
            == {POL_RESET, CFG_RESET, PD_RESET})) // [RULE19]
    else $error("fields changed outside byte end");

  decode_a: assert property (@(posedge sclk) disable iff (link_rst)
    byte_done |=> ({channel_select_b2, channel_select_b1, channel_select_b0}
                   == $past(ctrl_word[CHAN_MSB:CHAN_LSB]))
                  && polarity_select == $past(ctrl_word[POL_BIT])
                  && input_config_select == $past(ctrl_word[CFG_BIT])) // [RULE12]
    else $error("control fields decoded wrongly");

  result_len_a: assert property (@(posedge sclk) disable iff (link_rst)
    $rose(state_reg == LINK_CONVERT) |-> result_body_s) // [RULE17]
    else $error("result phase length wrong");

  strobe_pulse_a: assert property (@(negedge sclk) disable iff (link_rst)
    $rose(strobe_reg) |=> !strobe_reg) // [RULE16]
    else $error("strobe longer than one period");

  dout_quiet_a: assert property (@(negedge sclk) disable iff (link_rst)
    (state_reg != LINK_CONVERT) |=> !dout_reg) // [RULE4]
    else $error("data output not zero outside result");

  oe_release_a: assert property (@(posedge sclk) disable iff (link_rst)
    cs_n |-> !oe_reg) // [RULE18]
    else $error("outputs driven with select high");

  abort_a: assert property (@(posedge sclk) disable iff (rst)
    !hw_power_off_n |-> (state_reg == LINK_HUNT && !strobe_reg)) // [RULE9]
    else $error("conversion survived shutdown");

endmodule : adc_control_byte_power_modes

// ---- adc_control_byte_power_modes_tb.sv ----
// testbench of the control-byte decoder and power sequencer
// assumes the host model drives the link; the bench drives clk, rst, shutdown and result
module adc_control_byte_power_modes_tb
  import adc_ctl_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  localparam int POR_SIM = 20;

  logic         clk, rst, hw_power_off_n;
  logic  [11:0] result_data, res;
  logic  [7:0]  ctrl;
  logic  [2:0]  prev;
  wire          sclk, cs_n, din, dout, dout_oe, conversion_strobe, strobe_oe;
  wire          channel_select_b2, channel_select_b1, channel_select_b0;
  wire          polarity_select, input_config_select, power_mode_hi, power_mode_lo;
  wire          conv_ready;
  power_state_t power_state;
  power_state_t exp_ps [4];
  int           n_errors = 0;
  int           tests_run = 0;
  int           strb, stray, k, m;

  always #5 clk = ~clk;

  adc_control_byte_power_modes #(.POR_CYCLES_P(POR_SIM)) DUT
  (
    .clk, .rst, .sclk, .cs_n, .din, .hw_power_off_n, .result_data, .dout, .dout_oe,
    .conversion_strobe, .strobe_oe, .channel_select_b2, .channel_select_b1,
    .channel_select_b0, .polarity_select, .input_config_select, .power_mode_hi,
    .power_mode_lo, .power_state, .conv_ready
  );

  adc_host_model host
  (
    .sclk, .cs_n, .din, .dout, .dout_oe, .conversion_strobe, .strobe_oe
  );

  // ==========================================================================
  // reporting
  task automatic complete_run;
    $display("tests_run %0d n_errors %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : complete_run

  task automatic check_vec(input logic [11:0] got, input logic [11:0] exp, input string what);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_vec

  task automatic check_state(input power_state_t got, input power_state_t exp,
                             input string what);
    tests_run++;
    if (got !== exp)
    begin
      n_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask : check_state

  task automatic wait_state(input power_state_t s);
    int i;
    for (i = 0; i < 60 && power_state !== s; i++)
      @(posedge clk);
    if (i == 60)
    begin
      n_errors++;
      $display("unexpected at %0t: power state wait ran out", $time);
      complete_run();
    end
  endtask : wait_state

  task automatic check_frame(input logic [7:0] c, input logic [11:0] r);
    #1;
    check_vec(12'(strb), 12'h001, "strobe periods");
    check_vec(res, r, "result bits");
    check_vec(12'(stray), 12'h000, "dout outside result");
    check_vec(12'({dout_oe, strobe_oe}), 12'h000, "outputs released");
    check_vec(12'({channel_select_b2, channel_select_b1, channel_select_b0}),
              12'(c[6:4]), "channel");
    check_vec(12'(polarity_select), 12'(c[3]), "polarity");
    check_vec(12'(input_config_select), 12'(c[2]), "input config");
    check_vec(12'({power_mode_hi, power_mode_lo}), 12'(c[1:0]), "power mode");
  endtask : check_frame

  // ==========================================================================
  // main sequence
  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    hw_power_off_n = 1'b1;
    result_data = 12'h000;
    exp_ps = '{PWR_FULL, PWR_FAST, PWR_REDUCED, PWR_NORMAL};
    repeat (6) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    check_state(power_state, PWR_RESET, "state in reset interval");
    check_vec(12'(conversion_strobe), 12'h000, "strobe after power-up");
    check_vec(12'({power_mode_hi, power_mode_lo}), 12'h003, "mode after power-up");
    // start bit sent inside the reset interval is ignored
    fork
      host.frame(8'h80, 0, 21, res, strb, stray);
      for (k = 0; k < 100 && conv_ready !== 1'b1; k++)
        @(posedge clk);
    join
    #1;
    check_vec(12'(k >= POR_SIM - 1 && k <= POR_SIM + 1), 12'h001, "reset interval");
    check_vec(12'(strb), 12'h000, "early start ignored");
    check_vec(res, 12'h000, "zeros before conversion");
    check_vec(12'(stray), 12'h000, "zeros before conversion");
    wait_state(PWR_NORMAL);
    check_state(power_state, PWR_NORMAL, "normal after power-up");
    $display("test power-on done");

    // every power mode, each byte entered from the previous mode
    for (m = 0; m < 4; m++)
    begin
      ctrl = {1'b1, 3'(2 * m + 1), m[0], m[1], 2'(m)};
      @(posedge clk);
      result_data <= 12'hc35 ^ 12'(m * 299);
      prev = {channel_select_b2, channel_select_b1, channel_select_b0};
      fork
        host.frame(ctrl, 1, 22, res, strb, stray);
        begin
          #100;
          check_vec(12'({channel_select_b2, channel_select_b1, channel_select_b0}),
                    12'(prev), "fields kept mid-byte");
          #350;
          check_state(power_state, PWR_CONVERT, "full power converting");
        end
      join
      check_frame(ctrl, result_data);
      wait_state(exp_ps[m]);
      check_state(power_state, exp_ps[m], "mode after conversion");
      $display("test mode %0d done", m);
    end

    // shutdown in mid-conversion with fast power-down programmed
    fork
      host.frame(8'hf5, 0, 21, res, strb, stray);
      begin
        #400;
        @(posedge clk);
        hw_power_off_n <= 1'b0;
        repeat (5) @(posedge clk);
        check_state(power_state, PWR_HW_OFF, "hardware shutdown");
        check_vec(12'({dout_oe, conversion_strobe, power_mode_hi, power_mode_lo}),
                  12'h003, "conversion aborted");
      end
    join
    @(posedge clk);
    hw_power_off_n <= 1'b1;
    wait_state(PWR_NORMAL);
    repeat (30) @(posedge clk);
    check_state(power_state, PWR_NORMAL, "nothing pending after release");
    host.frame(8'hb3, 4, 25, res, strb, stray);
    check_frame(8'hb3, result_data);
    wait_state(PWR_NORMAL);
    $display("test shutdown done");
    complete_run();
  end

endmodule : adc_control_byte_power_modes_tb

// ---- adc_ctl_pkg.sv ----
// constants, encodings and types of the control-byte decoder and power sequencer
// assumes a 100 MHz system clock and a host-driven serial clock on the link side
package adc_ctl_pkg;

  // ==========================================================================
  // control byte layout
  localparam int CTRL_WIDTH  = 8;
  localparam int START_BIT   = 7;
  localparam int CHAN_MSB    = 6;
  localparam int CHAN_LSB    = 4;
  localparam int POL_BIT     = 3;
  localparam int CFG_BIT     = 2;
  localparam int PD_HI_BIT   = 1;
  localparam int PD_LO_BIT   = 0;
  localparam int RESULT_BITS = 12;

  localparam logic [2:0] BIT_LAST   = 3'h7;
  localparam logic [2:0] BIT_FIRST  = 3'h1;
  localparam logic [3:0] CONV_FIRST = 4'h0;
  localparam logic [3:0] CONV_LAST  = 4'hC;

  // ==========================================================================
  // reset values of the decoded fields
  localparam logic [2:0] CHAN_RESET = 3'h0;
  localparam logic       POL_RESET  = 1'h0;
  localparam logic       CFG_RESET  = 1'h0;
  localparam logic [1:0] PD_RESET   = 2'h3;

  // ==========================================================================
  // power mode codes
  localparam logic [1:0] PD_FULL_OFF = 2'h0;
  localparam logic [1:0] PD_FAST_OFF = 2'h1;
  localparam logic [1:0] PD_REDUCED  = 2'h2;
  localparam logic [1:0] PD_NORMAL   = 2'h3;

  // ==========================================================================
  // timing
  localparam int CLK_FREQ_MHZ = 100;
  localparam int POR_TIME_US  = 10;
  localparam int POR_CYCLES   = POR_TIME_US * CLK_FREQ_MHZ;
  localparam int POR_CNT_W    = 16;

  // ==========================================================================
  // state types
  typedef enum logic [1:0] {
    LINK_HUNT    = 2'h0,
    LINK_SHIFT   = 2'h1,
    LINK_CONVERT = 2'h3
  } link_state_t;

  typedef enum logic [2:0] {
    PWR_RESET   = 3'h0,
    PWR_NORMAL  = 3'h1,
    PWR_CONVERT = 3'h3,
    PWR_REDUCED = 3'h2,
    PWR_FAST    = 3'h6,
    PWR_FULL    = 3'h7,
    PWR_HW_OFF  = 3'h5
  } power_state_t;

  // ==========================================================================
  // power state entered once a conversion has finished
  function automatic power_state_t decode_power_mode(input logic [1:0] mode);
    power_state_t st;
    st = PWR_NORMAL;
    unique case (mode)
      PD_FULL_OFF: st = PWR_FULL;
      PD_FAST_OFF: st = PWR_FAST;
      PD_REDUCED:  st = PWR_REDUCED;
      PD_NORMAL:   st = PWR_NORMAL;
    endcase
    return st;
  endfunction : decode_power_mode

endpackage : adc_ctl_pkg

// ---- adc_host_model.sv ----
// serial host model: clock master of the link, clock idle low, msb first
// assumes the device drives dout and strobe on falling sclk, released while deselected
module adc_host_model
  import adc_ctl_pkg::*;
(
  output logic      sclk,
  output logic      cs_n,
  output logic      din,
  input  wire logic dout,
  input  wire logic dout_oe,
  input  wire logic conversion_strobe,
  input  wire logic strobe_oe
);
  timeunit 1ns;
  timeprecision 1ps;

  // ==========================================================================
  // idle: clock stands still low, select high
  initial
  begin
    sclk = 1'b0;
    cs_n = 1'b1;
    din  = 1'b1;
  end

  // ==========================================================================
  // one frame: lead zeros, control byte, then zeros; samples on rising sclk
  task automatic frame(input logic [7:0] ctrl, input int lead, input int n,
                       output logic [11:0] res, output int strb, output int stray);
    int i;
    res = 12'h000;
    strb = 0;
    stray = 0;
    cs_n <= 1'b0;
    for (i = 0; i < n; i++)
    begin
      // data set up half a period before the rising edge
      din <= (i >= lead && i < lead + 8) ? ctrl[lead + 7 - i] : 1'b0;
      #16;
      if (strobe_oe === 1'b1 && conversion_strobe === 1'b1)
        strb++;
      if (i >= lead + 9 && i <= lead + 20)
        res = {res[10:0], dout};
      else if (dout_oe === 1'b1 && dout !== 1'b0)
        stray++;
      sclk = 1'b1;
      #16;
      sclk = 1'b0;
    end
    #16;
    cs_n <= 1'b1;
    // released line does not keep its last level
    din <= ~din;
  endtask : frame

endmodule : adc_host_model

// ---- level_sync.sv ----
// two-flop synchroniser for levels and toggles
// assumes the input is stable for several destination clock periods
module level_sync
  import adc_ctl_pkg::*;
#(
  parameter int               WIDTH       = 1,
  parameter logic [WIDTH-1:0] RESET_VALUE = '0
)
(
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] meta_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      meta_reg <= RESET_VALUE;
      sync_out <= RESET_VALUE;
    end
    else
    begin
      meta_reg <= async_in;
      sync_out <= meta_reg;
    end
  end

endmodule : level_sync

// ---- power_sequencer.sv ----
// power-on timer and power state sequencer on the system clock
// assumes all inputs are already synchronised to clk
module power_sequencer
  import adc_ctl_pkg::*;
#(
  parameter int POR_CYCLES_P = POR_CYCLES
)
(
  input  wire logic         clk,
  input  wire logic         rst,
  input  wire logic         hw_power_off_n_n_sync,
  input  wire logic         start_tgl_sync,
  input  wire logic         done_tgl_sync,
  input  wire logic         mode_hi,
  input  wire logic         mode_lo,
  output power_state_t      power_state,
  output logic              conv_ready
);

  localparam logic [POR_CNT_W-1:0] POR_LAST = POR_CNT_W'(POR_CYCLES_P - 1);
  localparam logic [POR_CNT_W-1:0] CNT_MAX  = '1;

  logic [POR_CNT_W-1:0] por_cnt_reg;
  logic                 start_seen_reg;
  logic                 done_seen_reg;
  logic                 start_evt;
  logic                 done_evt;

  assign start_evt = start_tgl_sync ^ start_seen_reg;
  assign done_evt  = done_tgl_sync ^ done_seen_reg;

  // ==========================================================================
  // power-on reset interval
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      por_cnt_reg <= '0;
      conv_ready  <= 1'b0;
    end
    else if (!conv_ready)
    begin
      por_cnt_reg <= por_cnt_reg + 1'b1;
      conv_ready  <= (por_cnt_reg == POR_LAST); // [RULE2]
    end
  end

  // ==========================================================================
  // event edges from the link
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      start_seen_reg <= 1'b0;
      done_seen_reg  <= 1'b0;
    end
    else
    begin
      start_seen_reg <= start_tgl_sync;
      done_seen_reg  <= done_tgl_sync;
    end
  end

  // ==========================================================================
  // power state
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      power_state <= PWR_RESET;
    end
    else if (!hw_power_off_n_n_sync)
    begin
      power_state <= PWR_HW_OFF; // [RULE7] [RULE9]
    end
    else
    begin
      unique case (power_state)
        PWR_RESET:
        begin
          if (conv_ready)
            power_state <= PWR_NORMAL; // [RULE1]
        end
        PWR_HW_OFF:
        begin
          power_state <= conv_ready ? PWR_NORMAL : PWR_RESET; // [RULE20]
        end
        PWR_CONVERT:
        begin
          if (done_evt)
            power_state <= decode_power_mode({mode_hi, mode_lo}); // [RULE5] [RULE6] [RULE8]
        end
        PWR_NORMAL, PWR_REDUCED, PWR_FAST, PWR_FULL:
        begin
          if (start_evt)
            power_state <= PWR_CONVERT; // [RULE10]
        end
        default:
        begin
          power_state <= PWR_NORMAL;
        end
      endcase
    end
  end

  // ==========================================================================
  // checks
  logic [POR_CNT_W-1:0] since_rst_reg;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      since_rst_reg <= '0;
    else if (since_rst_reg != CNT_MAX)
      since_rst_reg <= since_rst_reg + 1'b1;
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  por_time_a: assert property ($rose(conv_ready) |-> since_rst_reg == POR_CNT_W'(POR_CYCLES_P)) // [RULE2]
    else $error("ready rose at the wrong cycle");

  hw_off_a: assert property (!hw_power_off_n_n_sync |=> power_state == PWR_HW_OFF) // [RULE7]
    else $error("shutdown did not force hardware off");

  hold_conv_a: assert property ((power_state == PWR_CONVERT && !done_evt && hw_power_off_n_n_sync)
                                |=> power_state == PWR_CONVERT) // [RULE8]
    else $error("left conversion power before the end");

  start_full_a: assert property ((start_evt && hw_power_off_n_n_sync && power_state != PWR_RESET
                                  && power_state != PWR_HW_OFF && power_state != PWR_CONVERT)
                                 |=> power_state == PWR_CONVERT) // [RULE10]
    else $error("new byte did not restore full power");

  mode_map_a: assert property ((done_evt && hw_power_off_n_n_sync && power_state == PWR_CONVERT)
                               |=> power_state == decode_power_mode($past({mode_hi, mode_lo}))) // [RULE6]
    else $error("wrong power state after conversion");

  full_off_a: assert property ((done_evt && hw_power_off_n_n_sync && power_state == PWR_CONVERT
                                && {mode_hi, mode_lo} == PD_FULL_OFF)
                               |=> power_state == PWR_FULL) // [RULE5]
    else $error("full power-down not entered");

  hw_power_off_n_release_a: assert property ((power_state == PWR_HW_OFF && hw_power_off_n_n_sync && conv_ready)
                                   |=> power_state == PWR_NORMAL) // [RULE20]
    else $error("no return to idle after shutdown");

endmodule : power_sequencer
